// ### core/srw_supervisor.sv
// supervisor: reset generation, low-line warning, overvoltage flag, watchdog, chip-enable gate
// assumes comparator outputs and pins are asynchronous levels; synchronised here
//
// Overview of operation
// R01 - reset asserts on supply-low (internal) or reset-input-low (external mode)
// R02 - reset stays asserted for stretch period after monitored level recovers
// R03 - active-high reset output is always complement of active-low reset
// R04 - mode select low means internal thresholds; high means external thresholds
// R05 - external mode uses low-line pin; internal mode ignores it
// R06 - warning output low on supply margin (internal) or low-line input low (external)
// R07 - overvoltage flag low when sense exceeds reference; touches nothing else
// R08 - timeout select tied high uses default watchdog timeout; else alternate
// R09 - no kick edge past timeout: warning pulse, then fault held until edge
// R10 - warning pulse at least minimum width, leads fault by short interval
// R11 - chip-enable out low only when input low and reset not asserted
// R12 - input low at reset entry: keep output low until window ends or input rises
// R13 - manual reset held at least minimum width asserts reset after propagation delay; code asserts only if held low for min width plus that delay
// R14 - reset held while manual reset low; stretch begins after release
// R15 - manual reset pulled up internally; wired-OR sources allowed
// R16 - reset clears counters, forces watchdog outputs high, disables chip-enable gate
// R17 - comparators synchronised; every time is a cycle count from clock rate
module srw_supervisor
   import srw_pkg::*;
#(
   parameter longint unsigned STRETCH_CYCLES = STRETCH_CYC,
   parameter longint unsigned WD_DEFAULT_CYCLES = WD_DEFAULT_CYC,
   parameter longint unsigned WD_ALT_CYCLES = WD_DEFAULT_CYC / 2,
   parameter int unsigned WARN_CYCLES = WARN_CYC
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire srw_cmp_s cmp_in,
   input wire logic timeout_select_in,
   input wire logic manual_reset_n_in,
   input wire logic watchdog_kick_in,
   input wire logic chip_enable_n_in,
   output logic system_reset_n_out,
   output logic system_reset_out,
   output logic supply_warn_n_out,
   output logic overvoltage_flag_n_out,
   output logic watchdog_fault_n_out,
   output logic watchdog_warn_pulse_n_out,
   output logic chip_enable_n_out,
   output logic chip_enable_in_oe_out
);
   // counts must fit the 32-bit counters and leave room for the fault lead
   if (STRETCH_CYCLES < 1 || WD_DEFAULT_CYCLES <= WARN_LEAD_CYC || WD_ALT_CYCLES <= WARN_LEAD_CYC
       || WARN_CYCLES <= WARN_LEAD_CYC || STRETCH_CYCLES >= 64'h0000_0000_FFFF_FFFF
       || WD_DEFAULT_CYCLES >= 64'h0000_0000_FFFF_FFFF || WD_ALT_CYCLES >= 64'h0000_0000_FFFF_FFFF) begin : g_bad_timing
      $error("srw_supervisor: unusable timing parameters");
   end

   // =====================================
   // synchronisers, two stages on every outside level
   localparam int unsigned NSYNC = 10;
   // idle levels: comparators quiet, tsel high, manual reset high, kick low, ce high
   // so no false press, kick edge or flag follows reset
   localparam logic [NSYNC-1:0] SYNC_IDLE = 10'h00D;
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;
   wire [NSYNC-1:0] raw = {cmp_in, timeout_select_in, manual_reset_n_in, watchdog_kick_in, chip_enable_n_in};

   always_ff @(posedge clk_in or negedge reset_n_in) begin // see R17
      if (!reset_n_in) begin
         sync1_q <= SYNC_IDLE;
         sync2_q <= SYNC_IDLE;
      end else begin
         sync1_q <= raw;
         sync2_q <= sync1_q;
      end
   end

   srw_cmp_s cmp;
   logic tsel;
   logic mr_n;
   logic kick;
   logic ce_n;
   assign {cmp, tsel, mr_n, kick, ce_n} = sync2_q;

   // =====================================
   // reset source: threshold compare per mode
   logic level_low;
   assign level_low = cmp.mode_external ? cmp.reset_in_low : cmp.supply_low; // see R01, R04

   // manual reset qualification: low for the min width, then propagation delay
   logic [CNT_W-1:0] mr_cnt_q;
   logic mr_active_q;
   always_ff @(posedge clk_in or negedge reset_n_in) begin // see R13, R15
      if (!reset_n_in) begin
         mr_cnt_q <= '0;
         mr_active_q <= 1'b0;
      end else if (mr_n) begin
         mr_cnt_q <= '0;
         mr_active_q <= 1'b0; // see R14
      end else if (mr_cnt_q < CNT_W'(MR_MIN_CYC + MR_PROP_CYC)) begin
         mr_cnt_q <= mr_cnt_q + 1'b1;
      end else begin
         mr_active_q <= 1'b1;
      end
   end

   // stretch counter: reset held while any source stands, then stretched
   logic [CNT_W-1:0] stretch_q;
   logic rst_asserted_q;
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         stretch_q <= '0;
         rst_asserted_q <= 1'b1;
      end else if (level_low || mr_active_q) begin // see R01, R14
         stretch_q <= '0;
         rst_asserted_q <= 1'b1;
      end else if (rst_asserted_q) begin // see R02
         if (stretch_q >= CNT_W'(STRETCH_CYCLES - 1)) begin
            rst_asserted_q <= 1'b0;
         end else begin
            stretch_q <= stretch_q + 1'b1;
         end
      end
   end
   assign system_reset_n_out = ~rst_asserted_q;
   assign system_reset_out = rst_asserted_q; // see R03

   // =====================================
   // low-line warning and overvoltage flag
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         supply_warn_n_out <= 1'b1;
         overvoltage_flag_n_out <= 1'b1;
      end else begin
         // pin only reaches the comparator in external mode
         supply_warn_n_out <= ~(cmp.mode_external ? cmp.warn_level_low : cmp.supply_warn); // see R05, R06
         overvoltage_flag_n_out <= ~cmp.overvoltage; // see R07
      end
   end

   // =====================================
   // watchdog
   srw_wd_e wd_state_q;
   logic [CNT_W-1:0] wd_cnt_q;
   logic kick_d1_q;
   logic kick_edge;
   logic [CNT_W-1:0] wd_limit;
   logic wd_kicked_q;
   assign kick_edge = kick ^ kick_d1_q;
   // alternate timeout stands in for the capacitor-set period
   assign wd_limit = tsel ? CNT_W'(WD_DEFAULT_CYCLES) : CNT_W'(WD_ALT_CYCLES); // see R08

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         kick_d1_q <= 1'b0;
      end else begin
         kick_d1_q <= kick;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wd_state_q <= SRW_WD_RUN;
         wd_cnt_q <= '0;
         wd_kicked_q <= 1'b0;
      end else if (rst_asserted_q) begin // see R16
         wd_state_q <= SRW_WD_RUN;
         wd_cnt_q <= '0;
         wd_kicked_q <= 1'b0;
      end else begin
         case (wd_state_q)
            SRW_WD_RUN: begin
               if (kick_edge) begin
                  wd_cnt_q <= '0;
               end else if (wd_cnt_q >= wd_limit - CNT_W'(WARN_LEAD_CYC)) begin // see R09
                  wd_state_q <= SRW_WD_WARN;
                  wd_cnt_q <= '0;
               end else begin
                  wd_cnt_q <= wd_cnt_q + 1'b1;
               end
            end
            SRW_WD_WARN: begin
               // pulse always runs its full width, kick or not
               // a kick inside the pulse is remembered, else it would be lost
               if (wd_cnt_q >= CNT_W'(WARN_CYCLES - 1)) begin // see R10
                  wd_state_q <= (kick_edge || wd_kicked_q) ? SRW_WD_RUN : SRW_WD_FAULT; // see R09
                  wd_cnt_q <= '0;
                  wd_kicked_q <= 1'b0;
               end else begin
                  wd_cnt_q <= wd_cnt_q + 1'b1;
                  wd_kicked_q <= wd_kicked_q || kick_edge;
               end
            end
            SRW_WD_FAULT: begin
               if (kick_edge) begin // see R09
                  wd_state_q <= SRW_WD_RUN;
                  wd_cnt_q <= '0;
               end
            end
            default: begin
               wd_state_q <= SRW_WD_RUN;
               wd_cnt_q <= '0;
               wd_kicked_q <= 1'b0;
            end
         endcase
      end
   end

   // fault falls WARN_LEAD_CYC after the warning pulse falls
   logic fault_on;
   assign fault_on = (wd_state_q == SRW_WD_FAULT)
                     || (wd_state_q == SRW_WD_WARN && wd_cnt_q >= CNT_W'(WARN_LEAD_CYC) && !wd_kicked_q); // see R10
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         watchdog_warn_pulse_n_out <= 1'b1;
         watchdog_fault_n_out <= 1'b1;
      end else if (rst_asserted_q) begin // see R16
         watchdog_warn_pulse_n_out <= 1'b1;
         watchdog_fault_n_out <= 1'b1;
      end else begin
         watchdog_warn_pulse_n_out <= ~(wd_state_q == SRW_WD_WARN);
         watchdog_fault_n_out <= ~(fault_on && !(wd_state_q == SRW_WD_FAULT && kick_edge));
      end
   end

   // =====================================
   // chip-enable gate with write completion window
   logic [CNT_W-1:0] ce_cnt_q;
   logic ce_hold_q;
   logic rst_d1_q;
   always_ff @(posedge clk_in or negedge reset_n_in) begin // see R12
      if (!reset_n_in) begin
         rst_d1_q <= 1'b1;
         ce_hold_q <= 1'b0;
         ce_cnt_q <= '0;
      end else begin
         rst_d1_q <= rst_asserted_q;
         if (rst_asserted_q && !rst_d1_q && !ce_n) begin
            ce_hold_q <= 1'b1;
            ce_cnt_q <= '0;
         end else if (ce_hold_q) begin
            if (ce_n || ce_cnt_q >= CNT_W'(CE_HOLD_CYC - 1) || !rst_asserted_q) begin
               ce_hold_q <= 1'b0;
            end else begin
               ce_cnt_q <= ce_cnt_q + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         chip_enable_n_out <= 1'b1;
      end else begin
         // write protection: a live low passes during normal running or inside the hold window
         // entry cycle passes too, so a write in flight sees no one-cycle high blip
         chip_enable_n_out <= ~(!ce_n && (!rst_asserted_q || ce_hold_q || !rst_d1_q)); // see R11, R12, R16
      end
   end
   // input side of the gate is released during reset
   assign chip_enable_in_oe_out = ~rst_asserted_q; // see R16
endmodule

// ### include/srw_pkg.sv
// package for the supervisor reset/watchdog block
// assumes a single 100 MHz clock; all analog results arrive as digital levels
package srw_pkg;
   // =====================================
   // timing (figures as printed, derived counts)
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned STRETCH_MS = 200;
   localparam int unsigned WD_DEFAULT_MS = 1600;
   localparam int unsigned MR_MIN_US = 25;
   localparam int unsigned MR_PROP_US = 12;
   localparam int unsigned CE_HOLD_US = 15;
   localparam int unsigned WARN_MIN_US = 500;
   localparam int unsigned WARN_LEAD_NS = 70;
   localparam longint unsigned STRETCH_CYC = longint'(STRETCH_MS) * CLK_HZ / 1000;
   localparam longint unsigned WD_DEFAULT_CYC = longint'(WD_DEFAULT_MS) * CLK_HZ / 1000;
   localparam int unsigned MR_MIN_CYC = (MR_MIN_US * (CLK_HZ / 1_000_000));
   localparam int unsigned MR_PROP_CYC = (MR_PROP_US * (CLK_HZ / 1_000_000));
   localparam int unsigned CE_HOLD_CYC = (CE_HOLD_US * (CLK_HZ / 1_000_000));
   localparam int unsigned WARN_CYC = (WARN_MIN_US * (CLK_HZ / 1_000_000));
   localparam int unsigned WARN_LEAD_CYC = (WARN_LEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned CNT_W = 32;

   // =====================================
   // comparator inputs as one bundle
   typedef struct packed {
      logic supply_low;       // supply under reset threshold (internal mode)
      logic supply_warn;      // supply inside warning margin (internal mode)
      logic reset_in_low;     // reset input under reference (external mode)
      logic warn_level_low;   // warning_level_input under reference (external mode)
      logic mode_external;    // mode select at or above upper level
      logic overvoltage;      // overvoltage_sense above reference
   } srw_cmp_s;

   typedef enum logic [1:0] {
      SRW_WD_RUN = 2'b00,
      SRW_WD_WARN = 2'b01,
      SRW_WD_FAULT = 2'b10
   } srw_wd_e;
endpackage

// ### sim/srw_supervisor_sva.sv
// checker for the supervisor block, bound into srw_supervisor
// assumes the shortened sim counts; sees only the block's ports
module srw_supervisor_sva
   import srw_pkg::*;
#(
   parameter longint unsigned STRETCH_CYCLES = 100,
   parameter int unsigned WARN_CYCLES = 50
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire srw_cmp_s cmp_in,
   input wire logic manual_reset_n_in,
   input wire logic watchdog_kick_in,
   input wire logic chip_enable_n_in,
   input wire logic system_reset_n_out,
   input wire logic system_reset_out,
   input wire logic supply_warn_n_out,
   input wire logic overvoltage_flag_n_out,
   input wire logic watchdog_fault_n_out,
   input wire logic watchdog_warn_pulse_n_out,
   input wire logic chip_enable_n_out,
   input wire logic chip_enable_in_oe_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // =====================================
   // helper counters
   wire lvl_low = cmp_in.mode_external ? cmp_in.reset_in_low : cmp_in.supply_low;
   wire warn_sel = cmp_in.mode_external ? cmp_in.warn_level_low : cmp_in.supply_warn;
   logic [31:0] quiet_q, mr_low_q, rst_age_q, warn_len_q, kick_age_q;
   logic kick_prev_q;
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         {quiet_q, mr_low_q, rst_age_q, warn_len_q, kick_age_q} <= '0;
         kick_prev_q <= 1'b0;
      end else begin
         // saturate so the bound stays visible while quiet
         quiet_q <= (lvl_low || !manual_reset_n_in) ? '0 : quiet_q + 32'(quiet_q < STRETCH_CYCLES + 10);
         mr_low_q <= manual_reset_n_in ? '0 : mr_low_q + 32'h0000_0001;
         rst_age_q <= system_reset_n_out ? '0 : rst_age_q + 32'h0000_0001;
         warn_len_q <= watchdog_warn_pulse_n_out ? '0 : warn_len_q + 32'h0000_0001;
         kick_age_q <= (watchdog_kick_in != kick_prev_q) ? '0 : kick_age_q + 32'(kick_age_q < 16);
         kick_prev_q <= watchdog_kick_in;
      end
   end
   // =====================================
   // assertions
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   a_reset_complement: assert property (system_reset_out == !system_reset_n_out)
      else $error("reset outputs not complementary");
   a_level_reset: assert property (lvl_low [*4] |-> !system_reset_n_out)
      else $error("low level did not assert reset");
   a_stretch_min: assert property ($rose(system_reset_n_out) |-> quiet_q >= STRETCH_CYCLES)
      else $error("reset released before stretch ran out");
   a_manual_assert: assert property (mr_low_q == MR_MIN_CYC + MR_PROP_CYC + 20 |-> !system_reset_n_out)
      else $error("held manual reset not asserting reset");
   a_warn_select: assert property ($stable(warn_sel) [*4] |-> supply_warn_n_out == !warn_sel)
      else $error("supply warning wrong for mode");
   a_ovr_follow: assert property ($stable(cmp_in.overvoltage) [*4] |->
      overvoltage_flag_n_out == !cmp_in.overvoltage)
      else $error("overvoltage flag wrong");
   a_ce_hold_end: assert property (rst_age_q == CE_HOLD_CYC + 10 |-> chip_enable_n_out && !chip_enable_in_oe_out)
      else $error("chip enable still low after hold window");
   a_fault_release: assert property ($rose(watchdog_fault_n_out) |->
      kick_age_q < 8 || !system_reset_n_out || !$past(system_reset_n_out))
      else $error("fault released without kick edge");
   a_warn_width: assert property ($rose(watchdog_warn_pulse_n_out) && system_reset_n_out |->
      warn_len_q == WARN_CYCLES)
      else $error("warning pulse width wrong");
   a_wd_quiet_rst: assert property (!system_reset_n_out [*2] |-> watchdog_fault_n_out && watchdog_warn_pulse_n_out)
      else $error("watchdog outputs not high during reset");
   c_release: cover property ($rose(system_reset_n_out));
   c_fault: cover property ($fell(watchdog_fault_n_out));
   c_ce_hold: cover property (rst_age_q == CE_HOLD_CYC + 10);
endmodule

bind srw_supervisor srw_supervisor_sva #(.STRETCH_CYCLES(STRETCH_CYCLES), .WARN_CYCLES(WARN_CYCLES)) u_sva (.*);

// ### sim/srw_host_model.sv
// host side: kicks the watchdog and drives the memory chip enable
// assumes the bench says when the host runs and asks for memory cycles
module srw_host_model #(
   parameter int unsigned KICK_GAP = 100
) (
   input wire logic clk_in,
   input wire logic run_in,
   input wire logic mem_req_in,
   output logic kick_out,
   output logic chip_enable_n_out
);
   timeunit 1ns;
   timeprecision 1ns;
   int unsigned cnt_q = 0;
   logic kick_q = 1'b0;
   // a host in reset is silent, so its kick count restarts
   always @(posedge clk_in) begin
      if (!run_in) begin
         cnt_q <= 0;
      end else if (cnt_q == KICK_GAP - 1) begin
         cnt_q <= 0;
         kick_q <= ~kick_q;
      end else begin
         cnt_q <= cnt_q + 1;
      end
   end
   assign kick_out = kick_q;
   assign chip_enable_n_out = ~mem_req_in;
endmodule

// ### sim/srw_supervisor_bench.sv
// bench for srw_supervisor: edges noted with cycle windows, checked as seen
// assumes stretch 100, timeout 2000 or 1000, warning pulse 50
module srw_supervisor_bench
   import srw_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic val;
      logic [31:0] lo;
      logic [31:0] hi;
   } srw_note_s;
   logic clk_in = 1'b0, reset_n_in = 1'b0, mr_n = 1'b1, tsel = 1'b1, run = 1'b0, mem_req = 1'b0, watch = 1'b0;
   srw_cmp_s cmp = '0;
   logic kick, ce_n;
   logic [5:0] mon, prev;
   logic [31:0] cyc = '0;
   int n_mismatch = 0, tests_run = 0;
   srw_note_s exp_q[6][$];
   string nm[6] = '{"reset", "supply_warn", "overvoltage", "fault", "warn_pulse", "chip_enable"};
   initial forever #5 clk_in = ~clk_in;
   always @(posedge clk_in) cyc <= cyc + 32'h0000_0001;
   srw_supervisor #(.STRETCH_CYCLES(100), .WD_DEFAULT_CYCLES(2000), .WD_ALT_CYCLES(1000), .WARN_CYCLES(50)) dut (
      .clk_in, .reset_n_in, .cmp_in(cmp), .timeout_select_in(tsel), .manual_reset_n_in(mr_n),
      .watchdog_kick_in(kick), .chip_enable_n_in(ce_n), .system_reset_n_out(mon[0]), .system_reset_out(),
      .supply_warn_n_out(mon[1]), .overvoltage_flag_n_out(mon[2]), .watchdog_fault_n_out(mon[3]),
      .watchdog_warn_pulse_n_out(mon[4]), .chip_enable_n_out(mon[5]), .chip_enable_in_oe_out());
   srw_host_model host (.clk_in, .run_in(run & mon[0]), .mem_req_in(mem_req), .kick_out(kick), .chip_enable_n_out(ce_n));
   // =====================================
   // notes, checks, closing
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic note(input int i, input logic v, input int lo, input int hi);
      exp_q[i].push_back('{v, cyc + lo, cyc + hi});
   endtask
   task automatic cmp_edge(input int i, input logic v);
      srw_note_s n;
      tests_run++;
      n = exp_q[i].size() ? exp_q[i].pop_front() : srw_note_s'{~v, 32'h0000_0000, 32'h0000_0000};
      if (n.val !== v || cyc < n.lo || cyc > n.hi) begin
         n_mismatch++;
         $display("mismatch %s expected %b in %0d..%0d seen %b at %0d", nm[i], n.val, n.lo, n.hi, v, cyc);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk_in) begin
      for (int i = 0; i < 6; i++) begin
         if (watch && mon[i] !== prev[i]) cmp_edge(i, mon[i]);
      end
      prev <= mon;
   end
   initial begin
      #400000;
      n_mismatch++;
      report_and_stop();
   end
   // =====================================
   // scenarios
   initial begin
      logic k;
      int lim;
      void'($urandom(32'hdcea));
      tick(16);
      {reset_n_in, watch, run} <= 3'b111;
      note(0, 1'b1, 100, 110);
      tick(200);
      for (int i = 0; i < 4; i++) begin
         cmp.overvoltage <= ~cmp.overvoltage;
         note(2, cmp.overvoltage, 2, 6);
         tick(8 + $urandom % 24);
      end
      for (int m = 0; m < 4; m++) begin
         cmp.mode_external <= m[1];
         tick(10);
         {cmp.supply_warn, cmp.warn_level_low} <= m[0] ? 2'b01 : 2'b10;
         if (m[0] == m[1]) note(1, 1'b0, 2, 6);
         tick(20);
         {cmp.supply_warn, cmp.warn_level_low} <= 2'b00;
         if (m[0] == m[1]) note(1, 1'b1, 2, 6);
         tick(20);
      end
      cmp.mode_external <= 1'b0;
      mem_req <= 1'b1;
      note(5, 1'b0, 2, 6);
      tick(20);
      {cmp.supply_low, cmp.supply_warn} <= 2'b11;
      note(1, 1'b0, 2, 6);
      note(0, 1'b0, 2, 6);
      note(5, 1'b1, 1500, 1512);
      tick(2000);
      {cmp.supply_low, cmp.supply_warn} <= 2'b00;
      note(1, 1'b1, 2, 6);
      note(0, 1'b1, 100, 110);
      note(5, 1'b0, 100, 116);
      tick(200);
      {cmp.mode_external, mem_req} <= 2'b10;
      note(5, 1'b1, 2, 6);
      tick(20);
      cmp.reset_in_low <= 1'b1;
      note(0, 1'b0, 2, 6);
      tick(30);
      cmp.reset_in_low <= 1'b0;
      note(0, 1'b1, 100, 110);
      tick(150);
      // a short press must be ignored, the long one holds reset
      mr_n <= 1'b0;
      tick(1000 + $urandom % 2000);
      mr_n <= 1'b1;
      tick(50);
      mr_n <= 1'b0;
      note(0, 1'b0, 3700, 3712);
      tick(3800 + $urandom % 1000);
      mr_n <= 1'b1;
      note(0, 1'b1, 100, 110);
      tick(200);
      for (int t = 0; t < 2; t++) begin
         tsel <= ~t[0];
         lim = t ? 1000 : 2000;
         tick(150);
         k = kick;
         while (kick === k) tick(1);
         run <= 1'b0;
         note(4, 1'b0, lim - 10, lim + 2);
         note(3, 1'b0, lim - 3, lim + 10);
         note(4, 1'b1, lim + 40, lim + 52);
         tick(lim + 100);
         run <= 1'b1;
         note(3, 1'b1, 100, 112);
         tick(200);
      end
      for (int i = 0; i < 6; i++) begin
         if (exp_q[i].size() != 0) begin
            n_mismatch++;
            $display("mismatch %s expected edge seen none", nm[i]);
         end
      end
      report_and_stop();
   end
endmodule
